//--- pcrc_pkg.sv
// Package of constants for the programmable CRC generator
package pcrc_pkg;
  // ****************************************
  // Register map (word-aligned byte offsets)
  // ****************************************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TAPS = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_LEN_LSB = 0;
  localparam int CTL_START_BIT = 4;
  localparam int CTL_EMPTY_BIT = 6;
  localparam int CTL_FULL_BIT = 7;
  localparam int CTL_COUNT_LSB = 8;
  localparam int CTL_IDLE_STOP_BIT = 13;
  localparam logic [3:0] LEN_RESET = 4'h0;
  localparam logic [15:0] TAPS_RESET = 16'h0000;
  localparam logic [15:0] TAPS_MASK = 16'hFFFE;
  // ****************************************
  // FIFO geometry
  // ****************************************
  localparam logic [3:0] LEN_SMALL_MAX = 4'h7;
  localparam logic [4:0] DEPTH_LARGE_WORDS = 5'h08;
  localparam logic [4:0] DEPTH_SMALL_WORDS = 5'h10;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b01,
    SH_SHIFT = 2'b10
  } pcrc_state_t;
endpackage : pcrc_pkg

//--- pcrc_shift_if.sv
// Interface between the control logic and the serial shifter
`timescale 1ns/1ns
interface pcrc_shift_if;
  logic bit_valid;
  logic data_bit;
  logic clear;
  logic [15:0] taps;
  logic [3:0] len_m1;
  logic [15:0] remainder;
  modport ctrl (output bit_valid, data_bit, clear, taps, len_m1,
    input remainder);
  modport shifter (input bit_valid, data_bit, clear, taps, len_m1,
    output remainder);
endinterface : pcrc_shift_if

//--- pcrc_shifter.sv
// Serial CRC remainder shifter with programmable taps and length
`timescale 1ns/1ns
module pcrc_shifter (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  pcrc_shift_if.shifter sif
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic fb;
  // ****************************************
  // Feedback network
  // ****************************************
  always_comb begin
    fb = sif.data_bit ^ crc_reg[sif.len_m1];
    crc_next = crc_reg << 1;
    crc_next[0] = fb;
    for (int n = 1; n < 16; n++) begin
      if (sif.taps[n]) begin
        crc_next[n] = crc_reg[n - 1] ^ fb;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      crc_reg <= 16'h0000;
    end else if (clk_en) begin
      if (sif.clear) begin
        crc_reg <= 16'h0000;
      end else if (sif.bit_valid) begin
        crc_reg <= crc_next;
      end
    end
  end
  // Only the programmed length is visible
  always_comb begin
    sif.remainder = 16'h0000;
    for (int n = 0; n < 16; n++) begin
      if (n <= int'(sif.len_m1)) begin
        sif.remainder[n] = crc_reg[n];
      end
    end
  end
endmodule : pcrc_shifter

//--- pcrc_top.sv
// Programmable CRC generator with word FIFO and Avalon-MM slave
// Overview of operation
// - Each set tap bit n enables feedback XOR at term n, 1..15.
// - Length field holds polynomial length minus one; all ones is 16 bits.
// - Term zero feedback XOR is always applied.
// - For sixteen-bit polynomials the top term is always present.
// - FIFO depth is 8 words when length field exceeds 7, else 16.
// - Word is length-plus-one bits; smallest write unit is one byte.
// - Writing start bit one begins serial shifting of FIFO data.
// - Clearing start lets shifter run until FIFO empty, then stops.
// - Five-bit read-only count reports valid words in FIFO.
// - Full flag set when count reaches depth, else clear.
// - Empty flag set when count is zero; reads one after reset.
// - Write while full wraps count to zero, with no interrupt.
// - Interrupt raised when count goes from one to zero.
// - Sleep freezes the module in place; it resumes afterwards.
// - Idle-stop set: idle acts like sleep but interrupts still pass.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
module pcrc_top #(
  parameter int MAX_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic crc_irq
);
  // ****************************************
  // Declarations
  // ****************************************
  pcrc_shift_if sif ();
  logic run_en;
  logic [3:0] len_reg;
  logic start_reg;
  logic idle_stop_reg;
  logic [15:0] taps_reg;
  logic [15:0] fifo_mem [MAX_DEPTH];
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic [4:0] depth;
  logic full;
  logic empty;
  logic [15:0] word_reg;
  logic [3:0] bit_idx_reg;
  pcrc_pkg::pcrc_state_t state_reg;
  logic pop;
  logic push;
  logic last_bit;
  logic ack_reg;
  logic irq_reg;
  logic wr_ctl;
  logic wr_taps;
  logic wr_data;
  logic [15:0] data_word;
  // ****************************************
  // Enables and decode
  // ****************************************
  // Sleep always freezes; idle only freezes when idle_stop is set
  assign run_en = clk_en && !sleep_req &&
    !(idle_req && idle_stop_reg);
  // One wait cycle per access gives a registered answer
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end
  always_comb begin
    wr_ctl = 1'b0;
    wr_taps = 1'b0;
    wr_data = 1'b0;
    if (avs_write && ack_reg) begin
      if (avs_address == pcrc_pkg::ADDR_CONTROL) begin
        wr_ctl = 1'b1;
      end else if (avs_address == pcrc_pkg::ADDR_TAPS) begin
        wr_taps = 1'b1;
      end else if (avs_address == pcrc_pkg::ADDR_DATA) begin
        wr_data = 1'b1;
      end
    end
  end
  // ****************************************
  // Control and tap registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      len_reg <= pcrc_pkg::LEN_RESET;
      start_reg <= 1'b0;
      idle_stop_reg <= 1'b0;
    end else if (wr_ctl) begin
      if (avs_byteenable[0]) begin
        len_reg <= avs_writedata[pcrc_pkg::CTL_LEN_LSB +: 4];
        start_reg <= avs_writedata[pcrc_pkg::CTL_START_BIT];
      end
      if (avs_byteenable[1]) begin
        idle_stop_reg <= avs_writedata[pcrc_pkg::CTL_IDLE_STOP_BIT];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      taps_reg <= pcrc_pkg::TAPS_RESET;
    end else if (wr_taps) begin
      if (avs_byteenable[0]) begin
        taps_reg[7:0] <= avs_writedata[7:0] & pcrc_pkg::TAPS_MASK[7:0];
      end
      if (avs_byteenable[1]) begin
        taps_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end
  // ****************************************
  // FIFO
  // ****************************************
  assign depth = (len_reg > pcrc_pkg::LEN_SMALL_MAX) ?
    pcrc_pkg::DEPTH_LARGE_WORDS : pcrc_pkg::DEPTH_SMALL_WORDS;
  assign full = (count_reg == depth);
  assign empty = (count_reg == 5'h00);
  // Any byte lane write pushes; unwritten lanes read as zero
  assign data_word = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
    avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
  assign push = wr_data && run_en;
  assign last_bit = (bit_idx_reg == 4'h0);
  assign pop = run_en && !empty &&
    (state_reg == pcrc_pkg::SH_IDLE ? start_reg : last_bit);
  always_comb begin
    count_next = count_reg;
    if (push && full) begin
      count_next = 5'h00;
    end else if (push && !pop) begin
      count_next = count_reg + 5'h01;
    end else if (pop && !push) begin
      count_next = count_reg - 5'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= 5'h00;
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
      if (push && full) begin
        rd_ptr_reg <= wr_ptr_reg;
      end else begin
        if (push) begin
          wr_ptr_reg <= (wr_ptr_reg + 4'h1) & 4'(depth - 5'h01);
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg + 4'h1) & 4'(depth - 5'h01);
        end
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push && !full) begin
      fifo_mem[wr_ptr_reg] <= data_word;
    end
  end
  // ****************************************
  // Serial shift sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= pcrc_pkg::SH_IDLE;
      bit_idx_reg <= 4'h0;
      word_reg <= 16'h0000;
    end else if (run_en) begin
      case (state_reg)
        pcrc_pkg::SH_IDLE: begin
          if (pop) begin
            word_reg <= fifo_mem[rd_ptr_reg];
            bit_idx_reg <= len_reg;
            state_reg <= pcrc_pkg::SH_SHIFT;
          end
        end
        pcrc_pkg::SH_SHIFT: begin
          if (!last_bit) begin
            bit_idx_reg <= bit_idx_reg - 4'h1;
          end else if (pop) begin
            word_reg <= fifo_mem[rd_ptr_reg];
            bit_idx_reg <= len_reg;
          end else begin
            state_reg <= pcrc_pkg::SH_IDLE;
          end
        end
        default: state_reg <= pcrc_pkg::SH_IDLE;
      endcase
    end
  end
  assign sif.bit_valid = run_en && (state_reg == pcrc_pkg::SH_SHIFT);
  assign sif.data_bit = word_reg[bit_idx_reg];
  assign sif.clear = 1'b0;
  assign sif.taps = taps_reg;
  assign sif.len_m1 = len_reg;
  pcrc_shifter u_shifter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sif(sif)
  );
  // ****************************************
  // Interrupt pulse
  // ****************************************
  // Not gated by run_en so a pending event still leaves while frozen
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (count_reg == 5'h01) && (count_next == 5'h00) &&
        !(push && full);
    end
  end
  assign crc_irq = irq_reg;
  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_address == pcrc_pkg::ADDR_CONTROL) begin
        avs_readdata[pcrc_pkg::CTL_LEN_LSB +: 4] <= len_reg;
        avs_readdata[pcrc_pkg::CTL_START_BIT] <= start_reg;
        avs_readdata[pcrc_pkg::CTL_EMPTY_BIT] <= empty;
        avs_readdata[pcrc_pkg::CTL_FULL_BIT] <= full;
        avs_readdata[pcrc_pkg::CTL_COUNT_LSB +: 5] <= count_reg;
        avs_readdata[pcrc_pkg::CTL_IDLE_STOP_BIT] <= idle_stop_reg;
      end else if (avs_address == pcrc_pkg::ADDR_TAPS) begin
        avs_readdata[15:0] <= taps_reg;
      end else if (avs_address == pcrc_pkg::ADDR_DATA) begin
        avs_readdata[15:0] <= sif.remainder;
      end
    end
  end
endmodule : pcrc_top

//--- pcrc_monitor.sv
// Checker for bus timing and status flags of the CRC generator
`timescale 1ns/1ns
module pcrc_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic crc_irq
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic rd_ok;
  logic rd_c;
  logic rd_t;
  logic rd_x;
  logic [4:0] cnt;
  logic [4:0] dep;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign rd_c = rd_ok && avs_address == pcrc_pkg::ADDR_CONTROL;
  assign rd_t = rd_ok && avs_address == pcrc_pkg::ADDR_TAPS;
  assign rd_x = rd_ok && !rd_c && !rd_t && avs_address != pcrc_pkg::ADDR_DATA;
  assign cnt = avs_readdata[12:8];
  assign dep = avs_readdata[3:0] > 4'h7 ? 5'h08 : 5'h10;
  property p_ack;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stray wait");
  property p_pulse; crc_irq |=> !crc_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("long irq");
  // Reset must clear outputs, so this one is not disabled by it
  property p_rst;
    disable iff (1'b0) sys_rst |=> !crc_irq && avs_readdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_empty; rd_c |-> avs_readdata[6] == (cnt == 5'h00); endproperty
  a_empty: assert property (p_empty) else $error("empty flag");
  property p_full; rd_c |-> avs_readdata[7] == (cnt == dep); endproperty
  a_full: assert property (p_full) else $error("full flag");
  property p_cnt;
    rd_c |-> cnt <= dep && avs_readdata[31:14] == 0 && !avs_readdata[5];
  endproperty
  a_cnt: assert property (p_cnt) else $error("count range");
  property p_tap; rd_t |-> avs_readdata[31:16] == 0 && !avs_readdata[0];
  endproperty
  a_tap: assert property (p_tap) else $error("tap bit 0");
  property p_unmap; rd_x |-> avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  c_irq: cover property (crc_irq);
  c_full: cover property (rd_c && avs_readdata[7]);
  c_unmap: cover property (rd_x);
endmodule // pcrc_monitor

bind pcrc_top pcrc_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .crc_irq(crc_irq));

//--- pcrc_top_tb.sv
// Self-checking bench for the CRC generator
`timescale 1ns/1ns
module pcrc_top_tb;
  // ****
  // Stimulus and checks
  // ****
  localparam logic [15:0] TAPS = 16'h1020;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sleep_req = 1'b0;
  logic idle_req = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic crc_irq;
  logic [31:0] q;
  logic [15:0] crc_m = 16'h0;
  int errors = 0;
  int num_checks = 0;
  int irqs = 0;
  pcrc_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .sleep_req(sleep_req), .idle_req(idle_req), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .crc_irq(crc_irq));
  initial forever #25 clk_sys = ~clk_sys;
  // Counted mid-cycle so the registered pulse is settled
  always @(negedge clk_sys) if (crc_irq === 1'b1) irqs++;
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      errors++;
      $display("Error %0t: no ack", $time);
    end
    // Read data stands from the edge before the accepting one, so take it at the accepting edge
    @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task ctl(input logic [3:0] len, input logic go, input logic idl);
    bus(1'b1, pcrc_pkg::ADDR_CONTROL, {18'h0, idl, 8'h0, go, len}, 4'h3);
  endtask
  task feed(input logic [15:0] w);
    logic fb;
    bus(1'b1, pcrc_pkg::ADDR_DATA, {16'h0, w}, 4'h3);
    for (int i = 15; i >= 0; i--) begin
      fb = w[i] ^ crc_m[15];
      crc_m = {crc_m[14:0], 1'b0} ^ ({16{fb}} & (TAPS | 16'h0001));
    end
  endtask
  // Each word popped from a count of one gives one pulse
  task drain(input int n0, input int k);
    int n;
    n = 0;
    while (irqs < n0 + k && n < 80) begin
      @(posedge clk_sys);
      n++;
    end
    chk(irqs, n0 + k);
    // Last word still shifts after the count empties
    repeat (20) @(posedge clk_sys);
    bus(1'b0, pcrc_pkg::ADDR_DATA, 32'h0, 4'h0);
    chk(q[15:0], crc_m);
    $display("run test done");
  endtask
  task t_reset;
    bus(1'b0, pcrc_pkg::ADDR_CONTROL, 32'h0, 4'h0);
    chk(q, 32'h0040);
    bus(1'b0, 4'hC, 32'h0, 4'h0);
    chk(q, 32'h0);
    bus(1'b1, pcrc_pkg::ADDR_TAPS, 32'hFFFF, 4'hF);
    bus(1'b0, pcrc_pkg::ADDR_TAPS, 32'h0, 4'h0);
    chk(q, 32'hFFFE);
    bus(1'b1, pcrc_pkg::ADDR_TAPS, {16'h0, TAPS}, 4'h3);
    $display("reset test done");
  endtask
  task t_fill(input logic [3:0] len, input logic [4:0] dep);
    int n0;
    n0 = irqs;
    ctl(len, 1'b0, 1'b0);
    repeat (dep) bus(1'b1, pcrc_pkg::ADDR_DATA, 32'hA5, 4'h1);
    // Idle cycle of the bus task keeps the count read legal
    bus(1'b0, pcrc_pkg::ADDR_CONTROL, 32'h0, 4'h0);
    chk(q[12:6], {dep, 2'b10});
    bus(1'b1, pcrc_pkg::ADDR_DATA, 32'h5A, 4'h1);
    bus(1'b0, pcrc_pkg::ADDR_CONTROL, 32'h0, 4'h0);
    chk(q[12:6], 7'h01);
    chk(irqs, n0);
    $display("fill test done");
  endtask
  // Freeze kinds: 0 enable low, 1 sleep, 2 idle stopped, 3 idle running
  task t_run(input int m);
    int n0;
    n0 = irqs;
    ctl(4'hF, 1'b1, m == 2);
    feed(16'hA5C3);
    feed({12'h123, 4'(m)});
    if (m == 3) ctl(4'hF, 1'b0, 1'b0);
    clk_en <= (m != 0);
    sleep_req <= (m == 1);
    idle_req <= (m >= 2);
    repeat (30) @(posedge clk_sys);
    bus(1'b0, pcrc_pkg::ADDR_CONTROL, 32'h0, 4'h0);
    chk(q[12:8], (m == 3) ? 5'h00 : 5'h01);
    clk_en <= 1'b1;
    sleep_req <= 1'b0;
    idle_req <= 1'b0;
    drain(n0, 2);
  endtask
  // Queued word, then start: flush until empty
  task t_start;
    int n0;
    feed(16'h0F0F);
    repeat (30) @(posedge clk_sys);
    bus(1'b0, pcrc_pkg::ADDR_CONTROL, 32'h0, 4'h0);
    chk(q[12:8], 5'h01);
    n0 = irqs;
    ctl(4'hF, 1'b1, 1'b0);
    drain(n0, 1);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_fill(4'h7, 5'h10);
    t_fill(4'h8, 5'h08);
    for (int m = 0; m < 4; m++) t_run(m);
    t_start();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
endmodule // pcrc_top_tb
